// [pbbm_pkg.sv]
/*
 * Shared constants and types for the Port B bus-matching block.
 * Assumes every file of the block imports this package whole.
 */
`default_nettype none

package pbbm_pkg;

    // ************************************************************
    // Widths and lanes
    // ************************************************************
    localparam int PBBM_LONG_BITS = 36;
    localparam int PBBM_WORD_BITS = 18;
    localparam int PBBM_BYTE_BITS = 9;

    // Width encodings of the port.
    typedef enum logic [1:0] {
        PBBM_W_LONG = 2'h0,
        PBBM_W_WORD = 2'h1,
        PBBM_W_BYTE = 2'h2
    } pbbm_width_t;

    // Configuration taken when master reset completes.
    typedef struct packed {
        pbbm_width_t width;
        logic        big_endian;
    } pbbm_cfg_t;

    localparam pbbm_cfg_t PBBM_CFG_RESET = '{
        width      : PBBM_W_LONG,
        big_endian : 1'b0
    };

    // Index of the last piece of a long word for each width.
    localparam logic [1:0] PBBM_LAST_LONG = 2'h0;
    localparam logic [1:0] PBBM_LAST_WORD = 2'h1;
    localparam logic [1:0] PBBM_LAST_BYTE = 2'h3;
    localparam logic [1:0] PBBM_IDX_FIRST = 2'h0;

    // ************************************************************
    // Pin synchroniser positions
    // ************************************************************
    localparam int PBBM_PIN_MATCH  = 0;
    localparam int PBBM_PIN_SIZE   = 1;
    localparam int PBBM_PIN_ENDIAN = 2;
    localparam int PBBM_PIN_MRST1  = 3;
    localparam int PBBM_PIN_MRST2  = 4;
    localparam int PBBM_PIN_PRST1  = 5;
    localparam int PBBM_PIN_PRST2  = 6;
    localparam int PBBM_PINS       = 7;

    // Reset pins idle high (inactive); selects idle low.
    localparam logic [6:0] PBBM_PIN_RESET = 7'h78;

endpackage : pbbm_pkg

`default_nettype wire

// [pbbm_lane_map.sv]
/*
 * Lane mapper: picks one piece of a long word in endian order, and
 * merges an incoming piece into a long word at its endian position.
 * Assumes a static configuration and a piece index below the count of
 * pieces of the selected width.
 */
`default_nettype none

module pbbm_lane_map
    import pbbm_pkg::*;
(
    input  wire logic [35:0] long_word,
    input  wire logic [35:0] piece_in,
    input  wire pbbm_cfg_t   cfg,
    input  wire logic [1:0]  index,
    output logic      [35:0] piece_out,
    output logic      [35:0] merged
);

    logic [3:0][8:0]  bytes_v;
    logic [1:0][17:0] halves_v;
    logic [1:0]       byte_lane;
    logic             half_lane;

    assign bytes_v  = long_word;
    assign halves_v = long_word;
    // Big endian starts at the top lane, little endian at the bottom.
    assign byte_lane = cfg.big_endian ? 2'h3 - index : index;
    assign half_lane = cfg.big_endian ? ~index[0] : index[0];

    always_comb
    begin
        logic [3:0][8:0]  mb;
        logic [1:0][17:0] mh;
        mb = bytes_v;
        mh = halves_v;
        // Lanes above the selected width carry zero; only the low piece
        // of the input is taken.
        case (cfg.width)
            PBBM_W_WORD:
            begin
                piece_out     = {18'h0, halves_v[half_lane]};
                mh[half_lane] = piece_in[17:0];
                merged        = mh;
            end
            PBBM_W_BYTE:
            begin
                piece_out     = {27'h0, bytes_v[byte_lane]};
                mb[byte_lane] = piece_in[8:0];
                merged        = mb;
            end
            default:
            begin
                piece_out = long_word;
                merged    = piece_in;
            end
        endcase
    end

endmodule : pbbm_lane_map

`default_nettype wire

// [pbbm_bus_match.sv]
/*
 * Port B bus matching: unpacks FIFO1 long words into long words, words
 * or bytes, packs Port B pieces into long words for FIFO2, and narrows
 * mailbox traffic to the selected width.
 * Assumes the FIFO memories, their flags and the mailbox handshake sit
 * outside, on the same clock; the select and reset pins are asynchronous.
 */
// The plain strobed port was chosen for this implementation.
// What this block does
// - Port width from match and size selects: long, word or byte.
// - Chosen width takes effect when master reset completes.
// - Pieces of a long word go most or least significant first.
// - Endian select is latched on the rising edge of both master resets.
// - Latched byte order takes effect when master reset completes.
// - Endian select is ignored in long-word width.
// - Memories hold whole long words; conversion sits outside them.
// - Mailbox data bypasses packing and unpacking.
// - Mailbox uses only the low lanes of the selected width.
// - Long-word read moves the whole long word to the output at once.
// - Narrow reads give the first piece, the rest from an aux register.
// - Output lanes outside the selected width are driven to zero.
// - Narrow writes collect pieces; the last piece commits the long word.
// - Input lanes outside the selected width are ignored.
// - Long-word writes map each Port B lane onto the same Port A lane.
// - Byte order is never applied to mailbox data.
`default_nettype none

module pbbm_bus_match
    import pbbm_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      rst,
    input  wire logic      bus_match_select,
    input  wire logic      port_b_size_select,
    input  wire logic      endian_or_fallthrough_select,
    input  wire logic      master_reset_fifo1_n,
    input  wire logic      master_reset_fifo2_n,
    input  wire logic      partial_reset_fifo1_n,
    input  wire logic      partial_reset_fifo2_n,
    input  wire logic      port_b_read,
    input  wire logic      port_b_write,
    input  wire logic      port_b_mailbox_select,
    input  wire logic [35:0] port_b_din,
    output logic      [35:0] port_b_dout,
    output logic             port_b_dout_valid,
    input  wire logic [35:0] f1_mem_data,
    input  wire logic        f1_mem_valid,
    output logic             f1_mem_pop,
    input  wire logic        f2_mem_ready,
    output logic      [35:0] f2_mem_data,
    output logic             f2_mem_push,
    input  wire logic [35:0] mail1_data,
    output logic      [35:0] mail2_data,
    output logic             mail2_write,
    output logic             cfg_applied,
    output pbbm_cfg_t        port_b_cfg
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [1:0] last_index(input pbbm_width_t w);
        case (w)
            PBBM_W_WORD: last_index = PBBM_LAST_WORD;
            PBBM_W_BYTE: last_index = PBBM_LAST_BYTE;
            default:     last_index = PBBM_LAST_LONG;
        endcase
    endfunction : last_index
    function automatic pbbm_width_t width_decode(input logic match,
                                                 input logic size);
        width_decode = !match ? PBBM_W_LONG
                     : !size  ? PBBM_W_WORD : PBBM_W_BYTE;
    endfunction : width_decode
    // Mailbox narrowing keeps native lane order, low lanes only.
    function automatic logic [35:0] mail_narrow(input logic [35:0] d,
                                                input pbbm_width_t w);
        case (w)
            PBBM_W_WORD: mail_narrow = {18'h0, d[17:0]};
            PBBM_W_BYTE: mail_narrow = {27'h0, d[8:0]};
            default:     mail_narrow = d;
        endcase
    endfunction : mail_narrow

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [PBBM_PINS-1:0] pin_raw;
    logic [PBBM_PINS-1:0] pin_s1;
    logic [PBBM_PINS-1:0] pin_s2;
    logic [PBBM_PINS-1:0] pin_s3;
    logic [PBBM_PINS-1:0] pin_q;

    assign pin_raw = {partial_reset_fifo2_n, partial_reset_fifo1_n,
                      master_reset_fifo2_n, master_reset_fifo1_n,
                      endian_or_fallthrough_select, port_b_size_select,
                      bus_match_select};
    // A change counts only once the second and third stages agree.
    genvar gi;
    generate
        for (gi = 0; gi < PBBM_PINS; gi++)
        begin : g_pin
            always_ff @(posedge clock)
            begin
                if (rst)
                begin
                    pin_s1[gi] <= PBBM_PIN_RESET[gi];
                    pin_s2[gi] <= PBBM_PIN_RESET[gi];
                    pin_s3[gi] <= PBBM_PIN_RESET[gi];
                    pin_q[gi]  <= PBBM_PIN_RESET[gi];
                end
                else
                begin
                    pin_s1[gi] <= pin_raw[gi];
                    pin_s2[gi] <= pin_s1[gi];
                    pin_s3[gi] <= pin_s2[gi];
                    if (pin_s2[gi] == pin_s3[gi])
                        pin_q[gi] <= pin_s3[gi];
                end
            end
        end
    endgenerate

    // ************************************************************
    // Configuration capture at master reset release
    // ************************************************************
    wire master_active = ~pin_q[PBBM_PIN_MRST1] | ~pin_q[PBBM_PIN_MRST2];
    wire unpack_clear  = ~pin_q[PBBM_PIN_MRST1] | ~pin_q[PBBM_PIN_PRST1];
    wire pack_clear    = ~pin_q[PBBM_PIN_MRST2] | ~pin_q[PBBM_PIN_PRST2];
    logic master_seen;

    // The port stays shut until a full master reset has been seen, so a
    // half-taken configuration can never steer the lanes.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            master_seen <= 1'b0;
            cfg_applied <= 1'b0;
            port_b_cfg  <= PBBM_CFG_RESET;
        end
        else if (master_active)
        begin
            master_seen <= 1'b1;
            cfg_applied <= 1'b0;
        end
        else if (master_seen)
        begin
            master_seen           <= 1'b0;
            cfg_applied           <= 1'b1;
            port_b_cfg.width      <= width_decode(pin_q[PBBM_PIN_MATCH],
                                        pin_q[PBBM_PIN_SIZE]);
            port_b_cfg.big_endian <= pin_q[PBBM_PIN_ENDIAN];
        end
    end

    // ************************************************************
    // FIFO1 unpacking
    // ************************************************************
    logic [1:0]  unpack_idx;
    logic [35:0] unpack_word;
    logic [35:0] unpack_piece;

    wire fetch_needed = unpack_idx == PBBM_IDX_FIRST;
    wire rd_fifo = port_b_read & ~port_b_mailbox_select & cfg_applied;
    wire rd_mail = port_b_read & port_b_mailbox_select & cfg_applied;
    // A fetch waits out the cycle in which the previous pop lands.
    wire rd_take = rd_fifo & ~unpack_clear
                 & (~fetch_needed | (f1_mem_valid & ~f1_mem_pop));
    wire rd_last = unpack_idx == last_index(port_b_cfg.width);
    wire [35:0] unpack_src = fetch_needed ? f1_mem_data : unpack_word;
    wire [1:0]  next_unpack_idx = rd_last ? PBBM_IDX_FIRST
                                          : 2'(unpack_idx + 2'h1);

    pbbm_lane_map u_unpack_map (
        .long_word (unpack_src),
        .piece_in  (36'h0),
        .cfg       (port_b_cfg),
        .index     (unpack_idx),
        .piece_out (unpack_piece),
        .merged    ()
    );

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            unpack_idx        <= PBBM_IDX_FIRST;
            unpack_word       <= 36'h0;
            port_b_dout       <= 36'h0;
            port_b_dout_valid <= 1'b0;
            f1_mem_pop        <= 1'b0;
        end
        else
        begin
            port_b_dout_valid <= rd_take | rd_mail;
            f1_mem_pop        <= rd_take & fetch_needed;
            if (rd_take)
                port_b_dout <= unpack_piece;
            else if (rd_mail)
                port_b_dout <= mail_narrow(mail1_data,
                                           port_b_cfg.width);
            if (rd_take & fetch_needed)
                unpack_word <= f1_mem_data;
            if (unpack_clear)
                unpack_idx <= PBBM_IDX_FIRST;
            else if (rd_take)
                unpack_idx <= next_unpack_idx;
        end
    end

    // ************************************************************
    // FIFO2 packing
    // ************************************************************
    logic [1:0]  pack_idx;
    logic [35:0] pack_word;
    logic [35:0] pack_merged;
    wire wr_fifo = port_b_write & ~port_b_mailbox_select & cfg_applied
                 & ~pack_clear & f2_mem_ready;
    wire wr_mail = port_b_write & port_b_mailbox_select & cfg_applied;
    wire wr_last = pack_idx == last_index(port_b_cfg.width);

    pbbm_lane_map u_pack_map (
        .long_word (pack_word),
        .piece_in  (port_b_din),
        .cfg       (port_b_cfg),
        .index     (pack_idx),
        .piece_out (),
        .merged    (pack_merged)
    );

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            pack_idx    <= PBBM_IDX_FIRST;
            pack_word   <= 36'h0;
            f2_mem_data <= 36'h0;
            f2_mem_push <= 1'b0;
            mail2_data  <= 36'h0;
            mail2_write <= 1'b0;
        end
        else
        begin
            f2_mem_push <= wr_fifo & wr_last;
            mail2_write <= wr_mail;
            if (wr_fifo & wr_last)
                f2_mem_data <= pack_merged;
            if (wr_fifo)
                pack_word <= pack_merged;
            if (wr_mail)
                mail2_data <= mail_narrow(port_b_din,
                                          port_b_cfg.width);
            if (pack_clear)
                pack_idx <= PBBM_IDX_FIRST;
            else if (wr_fifo)
                pack_idx <= wr_last ? PBBM_IDX_FIRST
                                    : 2'(pack_idx + 2'h1);
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking pbbm_cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_fetch_long;
        rd_take && fetch_needed && port_b_cfg.width == PBBM_W_LONG;
    endsequence
    sequence s_fetch_byte;
        rd_take && fetch_needed && port_b_cfg.width == PBBM_W_BYTE;
    endsequence

    property p_cfg_taken;
        $rose(cfg_applied) |-> port_b_cfg.big_endian ==
            $past(pin_q[PBBM_PIN_ENDIAN]) && port_b_cfg.width ==
            width_decode($past(pin_q[PBBM_PIN_MATCH]),
                         $past(pin_q[PBBM_PIN_SIZE]));
    endproperty
    a_cfg_taken: assert property (p_cfg_taken)
        else $error("configuration not taken from the pins at release");
    property p_cfg_hold;
        cfg_applied && $past(cfg_applied) |-> $stable(port_b_cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration changed while in operation");
    property p_long_read;
        s_fetch_long |=> port_b_dout == $past(f1_mem_data)
            && port_b_dout_valid && f1_mem_pop;
    endproperty
    a_long_read: assert property (p_long_read)
        else $error("long word read did not pass whole word");
    property p_byte_first;
        s_fetch_byte |=> port_b_dout[35:9] == 27'h0
            && port_b_dout[8:0] == (port_b_cfg.big_endian
            ? $past(f1_mem_data[35:27]) : $past(f1_mem_data[8:0]));
    endproperty
    a_byte_first: assert property (p_byte_first)
        else $error("first byte of long word on wrong lane");
    property p_word_second;
        rd_take && !fetch_needed && port_b_cfg.width == PBBM_W_WORD
            |=> port_b_dout[17:0] == (port_b_cfg.big_endian
            ? $past(unpack_word[17:0]) : $past(unpack_word[35:18]))
            && !f1_mem_pop;
    endproperty
    a_word_second: assert property (p_word_second)
        else $error("second word not served from aux register");
    property p_no_early_push;
        wr_fifo && !wr_last |=> !f2_mem_push;
    endproperty
    a_no_early_push: assert property (p_no_early_push)
        else $error("long word committed before its last piece");
    property p_long_write;
        wr_fifo && port_b_cfg.width == PBBM_W_LONG
            |=> f2_mem_push && f2_mem_data == $past(port_b_din);
    endproperty
    a_long_write: assert property (p_long_write)
        else $error("long word write lanes not mapped straight");
    property p_mail_word;
        rd_mail && port_b_cfg.width == PBBM_W_WORD |=> port_b_dout ==
            {18'h0, $past(mail1_data[17:0])} && !f1_mem_pop;
    endproperty
    a_mail_word: assert property (p_mail_word)
        else $error("word mailbox read not narrowed in native order");
    property p_clear_idx;
        unpack_clear && pack_clear |=> unpack_idx == PBBM_IDX_FIRST
            && pack_idx == PBBM_IDX_FIRST;
    endproperty
    a_clear_idx: assert property (p_clear_idx)
        else $error("piece counters not returned to the start");

endmodule : pbbm_bus_match

`default_nettype wire

// [pbbm_mem_model.sv]
/*
 * Memory-side partner: shows the head long word of the FIFO1 memory and
 * takes long words pushed into the FIFO2 memory.
 * Assumes the block's clock and a bench-driven clear and stall.
 */
`default_nettype none

module pbbm_mem_model
    import pbbm_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        stall,
    input  wire logic [3:0]  f1_depth,
    output logic      [35:0] f1_mem_data,
    output logic             f1_mem_valid,
    input  wire logic        f1_mem_pop,
    output logic             f2_mem_ready,
    input  wire logic [35:0] f2_mem_data,
    input  wire logic        f2_mem_push
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0]  head;
    logic        flip;
    logic [35:0] f2_last;
    logic [7:0]  f2_count;
    logic [7:0]  push_refused;

    function automatic logic [35:0] long_word(input logic [3:0] i);
        return {9'h1a0 + 9'(i), 9'h0b1 + 9'(i),
                9'h0c2 + 9'(i), 9'h1d3 + 9'(i)};
    endfunction : long_word

    // An empty memory shows a toggling pattern, so a stale word never
    // passes for a fresh one.
    assign f1_mem_valid = (head < f1_depth);
    assign f1_mem_data  = f1_mem_valid ? long_word(head) : {36{flip}};
    assign f2_mem_ready = !stall;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            flip         <= 1'b0;
            head         <= 4'h0;
            f2_count     <= 8'h0;
            push_refused <= 8'h0;
            f2_last      <= 36'h0;
        end
        else
        begin
            flip <= !flip;
            if (f1_mem_pop)
                head <= head + 4'h1;
            if (f2_mem_push && f2_mem_ready)
                f2_count <= f2_count + 8'h1;
            if (f2_mem_push && !f2_mem_ready)
                push_refused <= push_refused + 8'h1;
            if (f2_mem_push)
                f2_last <= f2_mem_data;
        end
    end
endmodule : pbbm_mem_model

`default_nettype wire

// [pbbm_bus_match_test.sv]
/*
 * Self-checking bench for the Port B bus-matching block.
 * Assumes the memory partner pbbm_mem_model and a 100 MHz clock.
 */
`default_nettype none

module pbbm_bus_match_test
    import pbbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        match;
        logic        size;
        logic        endian;
        pbbm_width_t width;
    } pbbm_row_t;

    logic clock = 1'b0, rst = 1'b1, stall = 1'b0, mem_clear = 1'b1;
    logic match = 1'b0, size = 1'b0, endian = 1'b0, mbox = 1'b0;
    logic mr1_n = 1'b1, mr2_n = 1'b1, pr1_n = 1'b1, pr2_n = 1'b1;
    logic rd = 1'b0, wr = 1'b0, mvalid, pop, ready, push, m2w, dv, applied;
    logic [35:0] din = 36'h0, mail1 = 36'h9_8765_4321;
    logic [35:0] dout, mdata, f2d, m2d, got, ex, mask;
    logic [3:0]  depth = 4'h2;
    logic        ok;
    pbbm_cfg_t   cfg;
    int          miscompares = 0, num_checks = 0, w, k, np;

    pbbm_row_t rows [6] = '{
        '{1'b0, 1'b0, 1'b0, PBBM_W_LONG}, '{1'b0, 1'b1, 1'b1, PBBM_W_LONG},
        '{1'b1, 1'b0, 1'b1, PBBM_W_WORD}, '{1'b1, 1'b0, 1'b0, PBBM_W_WORD},
        '{1'b1, 1'b1, 1'b1, PBBM_W_BYTE}, '{1'b1, 1'b1, 1'b0, PBBM_W_BYTE}};

    always #5 clock = !clock;

    pbbm_bus_match pbbm_bus_match_i (
        .clock(clock), .rst(rst), .bus_match_select(match),
        .port_b_size_select(size), .endian_or_fallthrough_select(endian),
        .master_reset_fifo1_n(mr1_n), .master_reset_fifo2_n(mr2_n),
        .partial_reset_fifo1_n(pr1_n), .partial_reset_fifo2_n(pr2_n),
        .port_b_read(rd), .port_b_write(wr), .port_b_mailbox_select(mbox),
        .port_b_din(din), .port_b_dout(dout), .port_b_dout_valid(dv),
        .f1_mem_data(mdata), .f1_mem_valid(mvalid), .f1_mem_pop(pop),
        .f2_mem_ready(ready), .f2_mem_data(f2d), .f2_mem_push(push),
        .mail1_data(mail1), .mail2_data(m2d), .mail2_write(m2w),
        .cfg_applied(applied), .port_b_cfg(cfg));

    pbbm_mem_model pbbm_mem_model_i (
        .clock(clock), .rst(mem_clear), .stall(stall), .f1_depth(depth),
        .f1_mem_data(mdata), .f1_mem_valid(mvalid), .f1_mem_pop(pop),
        .f2_mem_ready(ready), .f2_mem_data(f2d), .f2_mem_push(push));

    task automatic check(input string name, input logic [35:0] seen,
                         input logic [35:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic timed_out;
        check("handshake", 36'h0, 36'h1);
        tally_and_finish();
    endtask : timed_out

    // Piece k of a long word as it should appear on the low lanes.
    function automatic logic [35:0] piece(input logic [35:0] lw,
        input pbbm_width_t wd, input logic big, input int k);
        logic [8:0] b [4];
        b = '{lw[35:27], lw[26:18], lw[17:9], lw[8:0]};
        if (wd == PBBM_W_BYTE)
            return {27'h0, b[big ? k : 3 - k]};
        if (wd == PBBM_W_WORD)
            return (big == (k == 0)) ? {18'h0, b[0], b[1]}
                                     : {18'h0, b[2], b[3]};
        return lw;
    endfunction : piece

    task automatic configure(input pbbm_row_t r);
        int n;
        @(posedge clock);
        match     <= r.match;
        size      <= r.size;
        endian    <= r.endian;
        mem_clear <= 1'b1;
        mr1_n     <= 1'b0;
        mr2_n     <= 1'b0;
        repeat (8) @(posedge clock);
        check("closed", {35'h0, applied}, 36'h0);
        mr1_n     <= 1'b1;
        mr2_n     <= 1'b1;
        mem_clear <= 1'b0;
        for (n = 0; n < 20 && applied !== 1'b1; n++)
            @(negedge clock);
        if (n == 20)
            timed_out();
        @(posedge clock);
        endian <= !r.endian;
        check("width", 36'(cfg.width), 36'(r.width));
        mask = (r.width == PBBM_W_BYTE) ? 36'h0_0000_01ff :
               (r.width == PBBM_W_WORD) ? 36'h0_0003_ffff : 36'hf_ffff_ffff;
        np = (r.width == PBBM_W_BYTE) ? 4 : (r.width == PBBM_W_WORD) ? 2 : 1;
    endtask : configure

    task automatic read(input logic mb, input int tries);
        int n;
        for (n = 0; n < tries; n++)
        begin
            @(posedge clock);
            rd   <= 1'b1;
            mbox <= mb;
            @(posedge clock);
            rd <= 1'b0;
            @(negedge clock);
            if (dv === 1'b1)
                break;
        end
        ok  = (n < tries);
        got = dout;
    endtask : read

    task automatic write(input logic mb, input logic [35:0] d);
        @(posedge clock);
        wr   <= 1'b1;
        mbox <= mb;
        din  <= d;
        @(posedge clock);
        wr  <= 1'b0;
        din <= ~d;
    endtask : write

    task automatic wait_push(input int c);
        int n;
        for (n = 0; n < 6 && pbbm_mem_model_i.f2_count !== 8'(c); n++)
            @(negedge clock);
        if (n == 6)
            timed_out();
    endtask : wait_push

    initial
    begin
        repeat (8) @(negedge clock);
        check("reset cfg", 36'(cfg), 36'(PBBM_CFG_RESET));
        @(posedge clock);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            configure(rows[i]);
            for (w = 0; w < 2; w++)
            begin
                ex = pbbm_mem_model_i.long_word(4'(w));
                for (k = 0; k < np; k++)
                begin
                    read(1'b0, 8);
                    if (!ok)
                        timed_out();
                    check("piece", got, piece(ex, rows[i].width,
                          rows[i].endian, k));
                end
                for (k = 0; k < np; k++)
                    write(1'b0, piece(ex, rows[i].width, rows[i].endian, k)
                                | ~mask);
                wait_push(w + 1);
                check("fifo2", pbbm_mem_model_i.f2_last, ex);
            end
            read(1'b0, 1);
            check("empty read", {35'h0, ok}, 36'h0);
            read(1'b1, 1);
            check("mail1", got, mail1 & mask);
            write(1'b1, 36'h6_cafe_f00d);
            @(negedge clock);
            check("mail2 strobe", {35'h0, m2w}, 36'h1);
            check("mail2", m2d, 36'h6_cafe_f00d & mask);
            check("no push", 36'(pbbm_mem_model_i.f2_count), 36'h2);
        end
        configure(rows[4]);
        ex = pbbm_mem_model_i.long_word(4'h7);
        write(1'b0, piece(ex, PBBM_W_BYTE, 1'b1, 0));
        write(1'b0, piece(ex, PBBM_W_BYTE, 1'b1, 1));
        read(1'b0, 8);
        @(posedge clock);
        pr1_n <= 1'b0;
        pr2_n <= 1'b0;
        repeat (8) @(posedge clock);
        pr1_n <= 1'b1;
        pr2_n <= 1'b1;
        repeat (8) @(posedge clock);
        stall <= 1'b1;
        write(1'b0, 36'h0_0000_0155);
        stall <= 1'b0;
        read(1'b0, 8);
        ex = pbbm_mem_model_i.long_word(4'h1);
        check("after partial", got, piece(ex, PBBM_W_BYTE, 1'b1, 0));
        ex = pbbm_mem_model_i.long_word(4'h9);
        for (k = 0; k < 4; k++)
            write(1'b0, piece(ex, PBBM_W_BYTE, 1'b1, k));
        wait_push(1);
        check("packed", pbbm_mem_model_i.f2_last, ex);
        check("full push", 36'(pbbm_mem_model_i.push_refused),
              36'h0);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(negedge clock);
        check("rst cfg", 36'(cfg), 36'(PBBM_CFG_RESET));
        check("rst open", {35'h0, applied}, 36'h0);
        tally_and_finish();
    end
endmodule : pbbm_bus_match_test

`default_nettype wire
